// ### verilog/sir_device.sv
`timescale 1ns/1ps
// Behaviour
// - One bit per SCL cycle, SDA stable high
// - Idle high; START and STOP by SDA
// - SDA fall while SCL high starts transaction
// - Repeated START keeps bus, rematches address
// - STOP ends anywhere, except START's phase
// - Controller never stops in START phase
// - Address compared per bit, mismatch ignores
// - Target address 1011110, sent MSB first
// - Eighth address bit selects direction
// - Matching address acknowledged low
// - Received bytes acknowledged through ninth pulse
// - Controller stops on unacknowledged transfers
// - Controller acks reads, nacks last, stops
// - Write: address, index, data, STOP
// - Index advances after each stored byte
// - Read via index write, repeated START
// - Index frozen at FIFO readout register on reads
// - SDA open-drain only; SCL input only
// - Works up to 400 kHz SCL
module sir_device (
    input wire logic sys_clk,
    input wire logic nrst,
    sir_link_if.device link,
    output logic [7:0] regIndex,
    output logic [7:0] wrData,
    output logic wrStrobe,
    output logic rdStrobe,
    input wire logic [7:0] rdData,
    output logic busy
);
    typedef enum logic [2:0] {
        SIR_IDLE = 3'b000,
        SIR_ADDR = 3'b001,
        SIR_AACK = 3'b011,
        SIR_RXB = 3'b010,
        SIR_RACK = 3'b110,
        SIR_TXB = 3'b111,
        SIR_TACK = 3'b101,
        SIR_IGN = 3'b100
    } sir_state_t;

    typedef struct packed {
        logic [1:0] sclSync;
        logic [1:0] sdaSync;
        logic [sir_pkg::FILTER_LEN-1:0] sclHist;
        logic [sir_pkg::FILTER_LEN-1:0] sdaHist;
        logic sclF;
        logic sdaF;
        sir_state_t st;
        logic [3:0] bitCnt;
        logic [7:0] shift;
        logic isRead;
        logic haveIndex;
        logic startPhase;
        logic [7:0] index;
        logic [7:0] wdata;
        logic wr;
        logic rd;
        logic drvLow;
    } sir_dev_t;

    sir_dev_t q;
    sir_dev_t d;
    logic sclRise;
    logic sclFall;
    logic startEv;
    logic stopEv;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        d = q;
        d.wr = 1'b0;
        d.rd = 1'b0;
        d.sclSync = {q.sclSync[0], link.scl};
        d.sdaSync = {q.sdaSync[0], link.sda};
        d.sclHist = {q.sclHist[sir_pkg::FILTER_LEN-2:0], q.sclSync[1]};
        d.sdaHist = {q.sdaHist[sir_pkg::FILTER_LEN-2:0], q.sdaSync[1]};
        if (&q.sclHist) begin
            d.sclF = 1'b1;
        end else if (~|q.sclHist) begin
            d.sclF = 1'b0;
        end
        if (&q.sdaHist) begin
            d.sdaF = 1'b1;
        end else if (~|q.sdaHist) begin
            d.sdaF = 1'b0;
        end
        sclRise = d.sclF & ~q.sclF;
        sclFall = ~d.sclF & q.sclF;
        startEv = q.sclF & d.sclF & q.sdaF & ~d.sdaF;
        stopEv = q.sclF & d.sclF & ~q.sdaF & d.sdaF;
        if (sclFall) begin
            d.startPhase = 1'b0;
        end
        if (startEv) begin
            d.st = SIR_ADDR;
            d.bitCnt = 4'h0;
            d.drvLow = 1'b0;
            d.startPhase = 1'b1;
        end else if (stopEv && !q.startPhase) begin
            d.st = SIR_IDLE;
            d.drvLow = 1'b0;
        end else begin
            case (q.st)
                SIR_ADDR: begin
                    if (sclRise) begin
                        d.shift = {q.shift[6:0], q.sdaF};
                        d.bitCnt = q.bitCnt + 4'h1;
                        if (q.bitCnt < 4'h7 &&
                            q.sdaF != sir_pkg::TARGET_ADDR[3'(4'h6 - q.bitCnt)]) begin
                            d.st = SIR_IGN;
                        end
                        if (q.bitCnt == 4'h7) begin
                            d.isRead = q.sdaF;
                        end
                    end else if (sclFall && q.bitCnt == 4'h8) begin
                        d.st = SIR_AACK;
                        d.drvLow = 1'b1;
                    end
                end
                SIR_AACK: begin
                    if (sclFall) begin
                        d.bitCnt = 4'h0;
                        if (q.isRead) begin
                            d.st = SIR_TXB;
                            d.shift = rdData;
                            d.drvLow = ~rdData[7];
                            d.rd = 1'b1;
                        end else begin
                            d.st = SIR_RXB;
                            d.haveIndex = 1'b0;
                            d.drvLow = 1'b0;
                        end
                    end
                end
                SIR_RXB: begin
                    if (sclRise) begin
                        d.shift = {q.shift[6:0], q.sdaF};
                        d.bitCnt = q.bitCnt + 4'h1;
                    end else if (sclFall && q.bitCnt == 4'h8) begin
                        d.st = SIR_RACK;
                        d.drvLow = 1'b1;
                        if (!q.haveIndex) begin
                            d.index = q.shift;
                            d.haveIndex = 1'b1;
                        end else begin
                            d.wdata = q.shift;
                            d.wr = 1'b1;
                        end
                    end
                end
                SIR_RACK: begin
                    if (sclFall) begin
                        d.st = SIR_RXB;
                        d.drvLow = 1'b0;
                        d.bitCnt = 4'h0;
                        if (q.haveIndex && q.wr == 1'b0 && q.bitCnt == 4'h8) begin
                            d.bitCnt = 4'h0;
                        end
                    end
                    if (q.wr) begin
                        d.index = q.index + 8'h01;
                    end
                end
                SIR_TXB: begin
                    if (sclFall) begin
                        d.bitCnt = q.bitCnt + 4'h1;
                        if (q.bitCnt == 4'h7) begin
                            d.st = SIR_TACK;
                            d.drvLow = 1'b0;
                            if (q.index != sir_pkg::FIFO_READOUT_INDEX) begin
                                d.index = q.index + 8'h01;
                            end
                        end else begin
                            d.shift = {q.shift[6:0], 1'b0};
                            d.drvLow = ~q.shift[6];
                        end
                    end
                end
                SIR_TACK: begin
                    if (sclRise) begin
                        d.isRead = ~q.sdaF;
                    end else if (sclFall) begin
                        d.bitCnt = 4'h0;
                        if (q.isRead) begin
                            d.st = SIR_TXB;
                            d.shift = rdData;
                            d.drvLow = ~rdData[7];
                            d.rd = 1'b1;
                        end else begin
                            d.st = SIR_IGN;
                        end
                    end
                end
                default: begin
                    d.drvLow = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            q <= '{sclSync: 2'b11, sdaSync: 2'b11, sclHist: '1, sdaHist: '1,
                sclF: 1'b1, sdaF: 1'b1, st: SIR_IDLE, bitCnt: 4'h0,
                shift: 8'h00, isRead: 1'b0, haveIndex: 1'b0, startPhase: 1'b0,
                index: sir_pkg::INDEX_RESET, wdata: 8'h00, wr: 1'b0, rd: 1'b0,
                drvLow: 1'b0};
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign link.sdaDevOut = 1'b0;
    assign link.sdaDevOe = q.drvLow;
    assign regIndex = q.index;
    assign wrData = q.wdata;
    assign wrStrobe = q.wr;
    assign rdStrobe = q.rd;
    assign busy = (q.st != SIR_IDLE) && (q.st != SIR_IGN);
endmodule

// ### verilog/sir_pkg.sv
package sir_pkg;
    localparam logic [6:0] TARGET_ADDR = 7'h5e;
    localparam logic [7:0] FIFO_READOUT_INDEX = 8'h07;
    localparam logic [7:0] INDEX_RESET = 8'h00;
    localparam logic [7:0] RDATA_RESET = 8'h00;
    localparam int SYS_CLK_MHZ = 200;
    localparam int SCL_MAX_KHZ = 400;
    localparam int SCL_HALF_CYCLES = (SYS_CLK_MHZ * 1000) / (SCL_MAX_KHZ * 2);
    localparam logic [8:0] SCL_HALF = 9'(SCL_HALF_CYCLES);
    localparam int FILTER_LEN = 3;
endpackage

// ### verilog/sir_link_if.sv
`timescale 1ns/1ps
interface sir_link_if;
    logic sclOut;
    logic sclOe;
    logic sdaCtlOut;
    logic sdaCtlOe;
    logic sdaDevOut;
    logic sdaDevOe;
    logic scl;
    logic sda;
    assign scl = sclOe ? sclOut : 1'b1;
    assign sda = (sdaCtlOe ? sdaCtlOut : 1'b1) & (sdaDevOe ? sdaDevOut : 1'b1);
    modport device (input scl, input sda, output sdaDevOut, output sdaDevOe);
    modport host (input scl, input sda, output sclOut, output sclOe,
        output sdaCtlOut, output sdaCtlOe);
endinterface

// ### verilog/sir_host.sv
`timescale 1ns/1ps
module sir_host (
    input wire logic sys_clk,
    input wire logic nrst,
    sir_link_if.host link,
    input wire logic start,
    input wire logic isRead,
    input wire logic [7:0] index,
    input wire logic [7:0] wrByte,
    input wire logic [7:0] count,
    output logic wrTake,
    output logic [7:0] rdByte,
    output logic rdValid,
    output logic nackSeen,
    output logic busy
);
    typedef enum logic [2:0] {
        SIH_IDLE = 3'b000,
        SIH_START = 3'b001,
        SIH_BIT = 3'b011,
        SIH_ACK = 3'b010,
        SIH_STOP = 3'b110,
        SIH_RSTART = 3'b111
    } sir_hst_state_t;

    typedef struct packed {
        logic [1:0] sdaSync;
        sir_hst_state_t st;
        logic [8:0] tick;
        logic [1:0] ph;
        logic [3:0] bitCnt;
        logic [8:0] shift;
        logic [1:0] byteKind;
        logic rd;
        logic [7:0] left;
        logic sclLow;
        logic sdaLow;
        logic [7:0] rbyte;
        logic rv;
        logic take;
        logic nack;
    } sir_host_t;

    sir_host_t q;
    sir_host_t d;
    logic step;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        d = q;
        d.rv = 1'b0;
        d.take = 1'b0;
        d.sdaSync = {q.sdaSync[0], link.sda};
        step = (q.tick == sir_pkg::SCL_HALF);
        d.tick = (q.st == SIH_IDLE || step) ? 9'h000 : q.tick + 9'h001;
        case (q.st)
            SIH_IDLE: begin
                d.sclLow = 1'b0;
                d.sdaLow = 1'b0;
                if (start) begin
                    d.st = SIH_START;
                    d.rd = isRead;
                    d.left = count;
                    d.nack = 1'b0;
                    d.ph = 2'h0;
                end
            end
            SIH_START, SIH_RSTART: begin
                if (step) begin
                    d.ph = q.ph + 2'h1;
                    if (q.ph == 2'h0) begin
                        d.sclLow = 1'b0;
                        d.sdaLow = 1'b0;
                    end else if (q.ph == 2'h1) begin
                        d.sdaLow = 1'b1;
                    end else begin
                        d.sclLow = 1'b1;
                        d.st = SIH_BIT;
                        d.ph = 2'h0;
                        d.bitCnt = 4'h0;
                        d.byteKind = 2'h0;
                        d.shift = {sir_pkg::TARGET_ADDR, q.st == SIH_RSTART, 1'b1};
                    end
                end
            end
            SIH_BIT, SIH_ACK: begin
                if (step) begin
                    d.ph = q.ph + 2'h1;
                    if (q.ph == 2'h0) begin
                        d.sdaLow = ~q.shift[8];
                    end else if (q.ph == 2'h1) begin
                        d.sclLow = 1'b0;
                    end else begin
                        d.sclLow = 1'b1;
                        d.ph = 2'h0;
                        d.shift = {q.shift[7:0], q.sdaSync[1]};
                        d.bitCnt = q.bitCnt + 4'h1;
                        if (q.bitCnt == 4'h8) begin
                            d.bitCnt = 4'h0;
                            if (q.byteKind == 2'h3) begin
                                d.rbyte = q.shift[7:0];
                                d.rv = 1'b1;
                                d.left = q.left - 8'h01;
                                d.shift = {8'hff, (q.left == 8'h02)};
                                if (q.left == 8'h01) begin
                                    d.st = SIH_STOP;
                                end
                            end else if (q.sdaSync[1]) begin
                                d.nack = 1'b1;
                                d.st = SIH_STOP;
                            end else if (q.byteKind == 2'h0 && q.shift[0]) begin
                                d.byteKind = 2'h3;
                                d.shift = {8'hff, (q.left == 8'h01)};
                                if (q.left == 8'h00) begin
                                    d.st = SIH_STOP;
                                end
                            end else if (q.byteKind == 2'h0) begin
                                d.byteKind = 2'h1;
                                d.shift = {index, 1'b1};
                            end else if (q.rd) begin
                                d.st = SIH_RSTART;
                                d.sdaLow = 1'b0;
                            end else if (q.left == 8'h00) begin
                                d.st = SIH_STOP;
                            end else begin
                                d.byteKind = 2'h2;
                                d.shift = {wrByte, 1'b1};
                                d.take = 1'b1;
                                d.left = q.left - 8'h01;
                            end
                        end
                    end
                end
            end
            SIH_STOP: begin
                if (step) begin
                    d.ph = q.ph + 2'h1;
                    if (q.ph == 2'h0) begin
                        d.sdaLow = 1'b1;
                    end else if (q.ph == 2'h1) begin
                        d.sclLow = 1'b0;
                    end else begin
                        d.sdaLow = 1'b0;
                        d.st = SIH_IDLE;
                    end
                end
            end
            default: begin
                d.st = SIH_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            q <= '{sdaSync: 2'b11, st: SIH_IDLE, tick: 9'h000, ph: 2'h0,
                bitCnt: 4'h0, shift: 9'h000, byteKind: 2'h0, rd: 1'b0,
                left: 8'h00, sclLow: 1'b0, sdaLow: 1'b0, rbyte: 8'h00,
                rv: 1'b0, take: 1'b0, nack: 1'b0};
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign link.sclOut = 1'b0;
    assign link.sclOe = q.sclLow;
    assign link.sdaCtlOut = 1'b0;
    assign link.sdaCtlOe = q.sdaLow;
    assign wrTake = q.take;
    assign rdByte = q.rbyte;
    assign rdValid = q.rv;
    assign nackSeen = q.nack;
    assign busy = (q.st != SIH_IDLE);
endmodule

// ### verif/sir_link_monitor.sv
`timescale 1ns/1ps
module sir_link_monitor (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic scl,
    input wire logic sda,
    input wire logic sdaDevOut,
    input wire logic sdaDevOe
);
    typedef struct packed {
        logic sclP;
        logic sdaP;
        logic [7:0] falls;
        logic [7:0] sh;
        logic addrOk;
        logic rw;
    } sir_mon_t;
    sir_mon_t st_q;
    sir_mon_t st_d;
    logic startNow;
    assign startNow = st_q.sclP && scl && st_q.sdaP && !sda;
    ////////////////////////////////////////////////////////////////
    // Bit position since the last start, address and direction
    always_comb begin
        st_d = st_q;
        st_d.sclP = scl;
        st_d.sdaP = sda;
        if (startNow) begin
            st_d.falls = 8'h00;
        end else if (st_q.sclP && !scl && st_q.falls != 8'hff) begin
            st_d.falls = st_q.falls + 8'h01;
        end
        if (st_q.sclP && !scl && st_q.falls == 8'h08) begin
            st_d.addrOk = st_q.sh[7:1] == sir_pkg::TARGET_ADDR;
            st_d.rw = st_q.sh[0];
        end
        if (!st_q.sclP && scl) begin
            st_d.sh = {st_q.sh[6:0], sda};
        end
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= '{sclP: 1'b1, sdaP: 1'b1, default: '0};
        end else begin
            st_q <= st_d;
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    sequence s_start;
        startNow;
    endsequence
    sequence s_stop;
        scl && $rose(sda);
    endsequence
    sequence s_addrEnd;
        $fell(scl) && st_q.falls == 8'h08;
    endsequence
    sequence s_dataEnd;
        $fell(scl) && st_q.falls == 8'h11 && st_q.addrOk && !st_q.rw;
    endsequence
    property p_openDrain;
        sdaDevOe |-> !sdaDevOut;
    endproperty
    property p_changeLow;
        $changed(sdaDevOe) |-> !scl;
    endproperty
    property p_start;
        s_start |=> !sdaDevOe [*8];
    endproperty
    property p_stop;
        s_stop |=> !sdaDevOe [*8];
    endproperty
    property p_noDriveAddr;
        st_q.falls < 8'h09 |-> !sdaDevOe;
    endproperty
    property p_ackAddr;
        s_addrEnd ##0 st_q.sh[7:1] == sir_pkg::TARGET_ADDR |-> ##[1:20] sdaDevOe;
    endproperty
    property p_ackData;
        s_dataEnd |-> ##[1:20] sdaDevOe;
    endproperty
    property p_ackHold;
        sdaDevOe && $rose(scl) |-> sdaDevOe [*8];
    endproperty
    property p_writeQuiet;
        st_q.addrOk && !st_q.rw && st_q.falls > 8'h0a && st_q.falls < 8'h12 |-> !sdaDevOe;
    endproperty
    a_openDrain: assert property (p_openDrain) else $error("sda driven high");
    a_changeLow: assert property (p_changeLow) else $error("sda moved in high");
    a_start: assert property (p_start) else $error("drive after start");
    a_stop: assert property (p_stop) else $error("drive after stop");
    a_noDriveAddr: assert property (p_noDriveAddr) else $error("drive in address");
    a_ackAddr: assert property (p_ackAddr) else $error("address not acked");
    a_ackData: assert property (p_ackData) else $error("byte not acked");
    a_ackHold: assert property (p_ackHold) else $error("ack not held");
    a_writeQuiet: assert property (p_writeQuiet) else $error("drive while receiving");
endmodule

// ### verif/test_sensor_i2c_register_port.sv
`timescale 1ns/1ps
module test_sensor_i2c_register_port;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic start = 1'b0;
    logic isRead = 1'b0;
    logic [7:0] index = 8'h00;
    logic [7:0] count = 8'h00;
    logic [7:0] wrByte, rdByte, regIndex, wrData, rdData, bIdx;
    logic wrTake, rdValid, nackSeen, hostBusy, wrStrobe, rdStrobe, devBusy, bWr, bBusy, ack;
    logic [7:0] mem [0:255];
    logic [7:0] wrList [0:1] = '{8'ha1, 8'hb2};
    logic [7:0] expRd [0:3] = '{8'ha1, 8'hb2, 8'hf0, 8'hf1};
    logic [7:0] rdQ [$];
    logic [7:0] fifoCnt = 8'h00;
    int wrPos = 0;
    int bCnt = 0;
    int cyc = 0;
    int mismatches = 0;
    int cmpCount = 0;
    sir_link_if linkA();
    sir_link_if linkB();
    always #2.5 sys_clk = ~sys_clk;
    assign wrByte = wrList[wrPos % 2];
    assign rdData = (regIndex === sir_pkg::FIFO_READOUT_INDEX) ? 8'hf0 + fifoCnt : mem[regIndex];
    sir_host sir_host_inst (.sys_clk(sys_clk), .nrst(nrst), .link(linkA.host), .start(start),
        .isRead(isRead), .index(index), .wrByte(wrByte), .count(count), .wrTake(wrTake),
        .rdByte(rdByte), .rdValid(rdValid), .nackSeen(nackSeen), .busy(hostBusy));
    sir_device sir_device_inst (.sys_clk(sys_clk), .nrst(nrst), .link(linkA.device),
        .regIndex(regIndex), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
        .rdData(rdData), .busy(devBusy));
    sir_device sir_device_inst2 (.sys_clk(sys_clk), .nrst(nrst), .link(linkB.device),
        .regIndex(bIdx), .wrData(), .wrStrobe(bWr), .rdStrobe(), .rdData(8'h00), .busy(bBusy));
    sir_link_monitor sir_link_monitor_inst (.sys_clk(sys_clk), .nrst(nrst), .scl(linkA.scl),
        .sda(linkA.sda), .sdaDevOut(linkA.sdaDevOut), .sdaDevOe(linkA.sdaDevOe));
    ////////////////////////////////////////////////////////////////
    // Register bank and readout source behind the device
    always @(posedge sys_clk) begin
        if (wrStrobe === 1'b1) mem[regIndex] <= wrData;
        if (rdStrobe === 1'b1 && regIndex === sir_pkg::FIFO_READOUT_INDEX) fifoCnt <= fifoCnt + 1;
        if (rdValid === 1'b1) rdQ.push_back(rdByte);
        if (wrTake === 1'b1) wrPos <= wrPos + 1;
        if (bWr === 1'b1) bCnt <= bCnt + 1;
        cyc <= cyc + 1;
        if (cyc == 98000) begin
            mismatches++;
            reportAndStop();
        end
    end
    ////////////////////////////////////////////////////////////////
    task tk(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmpCount++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, got);
            mismatches++;
        end
    endtask
    task reportAndStop();
        $display("Checks %0d mismatches %0d", cmpCount, mismatches);
        if (mismatches == 0 && cmpCount > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task hostRun(input logic rd, input logic [7:0] idx, input logic [7:0] cnt);
        int n;
        isRead = rd;
        index = idx;
        count = cnt;
        start = 1'b1;
        tk(1);
        start = 1'b0;
        n = 0;
        while (hostBusy !== 1'b0 && n < 90000) begin
            tk(1);
            n++;
        end
    endtask
    // Bench-made link clock, 160 ns, low quarter, high half, low quarter
    task bbBit(input logic b, output logic s);
        linkB.sdaCtlOe = !b;
        tk(8);
        linkB.sclOe = 1'b0;
        tk(12);
        s = linkB.sda;
        tk(4);
        linkB.sclOe = 1'b1;
        tk(8);
    endtask
    task bbByte(input logic [7:0] v, output logic a);
        logic s;
        for (int i = 7; i >= 0; i--) bbBit(v[i], s);
        bbBit(1'b1, s);
        a = !s;
    endtask
    task bbStart();
        linkB.sdaCtlOe = 1'b0;
        tk(8);
        linkB.sclOe = 1'b0;
        tk(8);
        linkB.sdaCtlOe = 1'b1;
        tk(8);
        linkB.sclOe = 1'b1;
        tk(8);
    endtask
    task bbStop();
        linkB.sdaCtlOe = 1'b1;
        tk(8);
        linkB.sclOe = 1'b0;
        tk(8);
        linkB.sdaCtlOe = 1'b0;
        tk(8);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        linkB.sclOut = 1'b0;
        linkB.sclOe = 1'b0;
        linkB.sdaCtlOut = 1'b0;
        linkB.sdaCtlOe = 1'b0;
        for (int i = 0; i < 256; i++) mem[i] = 8'(i);
        tk(4);
        nrst = 1'b1;
        tk(2);
        hostRun(1'b0, 8'h05, 8'h02);
        chk("mem5", 8'ha1, mem[5]);
        chk("mem6", 8'hb2, mem[6]);
        chk("nackSeen", 8'h00, {7'h0, nackSeen});
        chk("regIndex", 8'h07, regIndex);
        tk(10);
        chk("devBusy", 8'h00, {7'h0, devBusy});
        $display("Test write burst done");
        hostRun(1'b1, 8'h05, 8'h04);
        chk("rdCount", 8'h04, 8'(rdQ.size()));
        for (int i = 0; i < 4; i++) chk("rdByte", expRd[i], rdQ[i]);
        chk("regIndex", 8'h07, regIndex);
        chk("fifoReads", 8'h02, fifoCnt);
        $display("Test read burst done");
        bbStart();
        bbByte(8'haa, ack);
        chk("ackWrong", 8'h00, {7'h0, ack});
        bbByte({sir_pkg::TARGET_ADDR, 1'b0}, ack);
        chk("ackNoStart", 8'h00, {7'h0, ack});
        bbStop();
        bbStart();
        bbByte(8'hbc, ack);
        chk("ackAddr", 8'h01, {7'h0, ack});
        bbByte(8'h10, ack);
        chk("ackIndex", 8'h01, {7'h0, ack});
        bbStart();
        bbByte(8'hbc, ack);
        chk("ackRestart", 8'h01, {7'h0, ack});
        bbByte(8'h20, ack);
        bbByte(8'h3c, ack);
        chk("ackData", 8'h01, {7'h0, ack});
        for (int i = 0; i < 3; i++) bbBit(1'b0, ack);
        bbStop();
        tk(20);
        chk("busyAfterStop", 8'h00, {7'h0, bBusy});
        chk("writes", 8'h01, 8'(bCnt));
        chk("bIndex", 8'h21, bIdx);
        // Stop inside the start's high phase must be ignored
        linkB.sdaCtlOe = 1'b1;
        tk(8);
        linkB.sdaCtlOe = 1'b0;
        tk(8);
        linkB.sclOe = 1'b1;
        tk(8);
        bbByte(8'hbc, ack);
        chk("ackStopInStart", 8'h01, {7'h0, ack});
        bbStop();
        $display("Test link faults done");
        reportAndStop();
    end
endmodule
